// ---- alert_qualifier.sv ----
`timescale 1ns/100ps
`default_nettype none
module alert_qualifier (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // conversion results
  input wire logic result_valid,
  input wire logic [15:0] result,
  input wire logic one_shot,
  // settings
  input wire logic [15:0] low_lim,
  input wire logic [15:0] high_lim,
  input wire sensor_pkg::cfg_s cfg,
  input wire logic reg_read,
  // alarm pin level
  output logic alert_pin
);

  logic hi;
  logic lo;
  logic [2:0] cnt;
  logic cnt_hi;
  logic [2:0] next_cnt;
  logic valid;
  logic sd_q;
  logic active;
  logic expect_hi;
  logic [7:0] pulse_cnt;
  logic is_int;
  logic enter_sd;
  logic leave_sd;

  // faults needed for a queue setting
  function automatic logic [2:0] need(input logic [1:0] ft);
    unique case (ft)
      2'h0: need = sensor_pkg::ft_need_0;
      2'h1: need = sensor_pkg::ft_need_1;
      2'h2: need = sensor_pkg::ft_need_2;
      2'h3: need = sensor_pkg::ft_need_3;
    endcase
  endfunction

  // limit comparison and next fault count
  assign hi = $signed(result) >= $signed(high_lim);
  assign lo = $signed(result) <= $signed(low_lim);
  assign next_cnt = !(hi || lo) ? 3'h0 :
                    (cnt != 3'h0 && cnt_hi == hi) ?
                    ((cnt == 3'h7) ? cnt : cnt + 3'h1) : 3'h1;
  assign valid = (hi || lo) && next_cnt >= need(cfg.ft);
  assign is_int = cfg.thermostat_mode_select == sensor_pkg::mode_interrupt;
  assign enter_sd = cfg.shutdown_control_bit && !sd_q;
  assign leave_sd = !cfg.shutdown_control_bit && sd_q;

  // fault counter, touched only by results and reset
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 3'h0;
      cnt_hi <= 1'b0;
    end else if (result_valid) begin
      cnt <= next_cnt;
      cnt_hi <= hi;
    end
  end

  // logical alarm state and event alternation
  always_ff @(posedge clk) begin
    if (reset) begin
      active <= 1'b0;
      expect_hi <= 1'b1;
      sd_q <= 1'b0;
    end else begin
      sd_q <= cfg.shutdown_control_bit;
      if (result_valid && valid && !is_int) begin
        active <= hi;
      end else if (result_valid && valid && hi == expect_hi) begin
        active <= 1'b1;
        expect_hi <= ~expect_hi;
      end else if (is_int && (reg_read || enter_sd)) begin
        active <= 1'b0;
      end else if (is_int && leave_sd && cnt >= need(cfg.ft)
                   && cnt_hi == expect_hi) begin
        active <= 1'b1;
        expect_hi <= ~expect_hi;
      end else if (is_int && pulse_cnt == 8'h01) begin
        active <= 1'b0;
      end
    end
  end

  // short pulse timer for single measurements in interrupt mode
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_cnt <= 8'h00;
    end else if (result_valid && valid && is_int && one_shot
                 && hi == expect_hi) begin
      pulse_cnt <= 8'(sensor_pkg::alert_pulse_cycles);
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  // pin polarity, comparator mode ignores shutdown entry
  always_ff @(posedge clk) begin
    if (reset) begin
      alert_pin <= 1'b1;
    end else begin
      alert_pin <= cfg.pol ? active : ~active;
    end
  end

endmodule
`default_nettype wire

// ---- sensor_pkg.sv ----
package sensor_pkg;

  // pointer codes of the data registers
  localparam logic [1:0] sel_temp = 2'h0;
  localparam logic [1:0] sel_cfg = 2'h1;
  localparam logic [1:0] sel_low = 2'h2;
  localparam logic [1:0] sel_high = 2'h3;

  // reset values
  localparam logic [1:0] select_reset = 2'h0;
  localparam logic [15:0] temp_reset = 16'h0000;
  localparam logic [15:0] cfg_reset = 16'h0000;
  localparam logic [15:0] low_reset = 16'h4B00;
  localparam logic [15:0] high_reset = 16'h5000;

  // fixed upper bits of the serial device address
  localparam logic [3:0] addr_fixed = 4'h9;

  // result masks for 9, 10, 11 and 12 bit resolution
  localparam logic [15:0] res_mask_9 = 16'hFF80;
  localparam logic [15:0] res_mask_10 = 16'hFFC0;
  localparam logic [15:0] res_mask_11 = 16'hFFE0;
  localparam logic [15:0] res_mask_12 = 16'hFFF0;

  // consecutive faults needed for each queue setting
  localparam logic [2:0] ft_need_0 = 3'h1;
  localparam logic [2:0] ft_need_1 = 3'h2;
  localparam logic [2:0] ft_need_2 = 3'h4;
  localparam logic [2:0] ft_need_3 = 3'h6;

  // timing
  localparam int clk_mhz = 50;
  localparam int conv_gap_us = 100;
  localparam int conv_gap_cycles = conv_gap_us * clk_mhz;
  localparam int alert_pulse_ns = 1000;
  localparam int alert_pulse_cycles = (alert_pulse_ns * clk_mhz + 999) / 1000;

  // thermostat mode
  typedef enum logic {
    mode_comparator = 1'b0,
    mode_interrupt = 1'b1
  } mode_e;

  // upper byte of the configuration register, msb first
  typedef struct packed {
    logic single_measure_bit;
    logic [1:0] res;
    logic [1:0] ft;
    logic pol;
    mode_e thermostat_mode_select;
    logic shutdown_control_bit;
  } cfg_s;

  // register write passed from the serial side to the core
  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] data;
  } wr_req_s;

endpackage

// ---- serial_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_master (
  // link clock and wire level
  input wire logic link_clk,
  input wire logic sda_in,
  // driven pins; sda_low pulls the line down
  output var logic scl,
  output var logic sda_low
);
  // bus idle at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit: data moves while scl low, sampled mid high phase
  task automatic put_bit(input logic b, output logic r);
    repeat (2) @(negedge link_clk);
    sda_low = !b;
    repeat (4) @(negedge link_clk);
    scl = 1'b1;
    repeat (3) @(negedge link_clk);
    r = sda_in;
    repeat (3) @(negedge link_clk);
    scl = 1'b0;
  endtask
  // start: sda falls while scl high
  task automatic start();
    sda_low = 1'b1;
    repeat (6) @(negedge link_clk);
    scl = 1'b0;
  endtask
  // stop: sda rises while scl high, line left released
  task automatic stop();
    repeat (2) @(negedge link_clk);
    sda_low = 1'b1;
    repeat (4) @(negedge link_clk);
    scl = 1'b1;
    repeat (4) @(negedge link_clk);
    sda_low = 1'b0;
    repeat (6) @(negedge link_clk);
  endtask
  // byte out msb first, then the device's acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = !r;
  endtask
  // byte in msb first; more acknowledges for another byte
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(!more, r);
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %0h seen %0h", nm, e, s); end end
module tb_top;
  localparam int gap = 50;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic conv_done = 1'b0;
  logic [11:0] cval = 12'h194;
  logic [2:0] strap = 3'h5;
  logic conv_start, alert_pin, shutdown_active, sda_oe, sda_out, scl, sda_low;
  logic [7:0] aw, ar, b[$];
  logic [4:0] ak;
  logic [15:0] w;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int cnt = 0;
  int n_conv = 0;
  int nc;
  // open drain data line with pull-up
  wire sda_line = !(sda_oe || sda_low);
  // core and link clocks, unrelated in phase
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  temp_sensor_register_access #(.conv_gap_cycles(gap)) uut (
    .clk(clk), .reset(reset), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_pins(strap), .conv_start(conv_start),
    .conv_done(conv_done), .conv_value(cval), .alert_pin(alert_pin),
    .shutdown_active(shutdown_active)
  );
  serial_master m (
    .link_clk(link_clk), .sda_in(sda_line), .scl(scl), .sda_low(sda_low)
  );
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // converter: one done pulse ten cycles after each start
  always @(negedge clk) begin
    conv_done <= (cnt == 1);
    if (conv_start) begin
      cnt <= 10;
      n_conv <= n_conv + 1;
    end else if (cnt != 0) cnt <= cnt - 1;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // expected temperature word for a resolution mask
  function automatic logic [15:0] exp_t(input logic [15:0] mk);
    return {cval, 4'h0} & mk;
  endfunction
  // write transfer: address then bytes; a holds one ack bit per byte
  task automatic wr(input logic [7:0] q[$], output logic [4:0] a);
    logic k;
    a = 5'h00;
    m.start();
    foreach (q[i]) begin
      m.put_byte(q[i], k);
      a[i] = k;
    end
    m.stop();
  endtask
  // read transfer of n bytes, last one refused by the master
  task automatic rd(input int n, output logic [7:0] d[$]);
    logic k;
    logic [7:0] v;
    d = {};
    m.start();
    m.put_byte(ar, k);
    for (int i = 0; i < n; i++) begin
      m.get_byte(i < n - 1, v);
      d.push_back(v);
    end
    m.stop();
  endtask
  task automatic rw(output logic [15:0] v);
    logic [7:0] d[$];
    rd(2, d);
    v = {d[0], d[1]};
  endtask
  // main sequence
  initial begin
    logic [15:0] rv[4];
    rv = '{sensor_pkg::temp_reset, sensor_pkg::cfg_reset,
           sensor_pkg::low_reset, sensor_pkg::high_reset};
    aw = {sensor_pkg::addr_fixed, strap, 1'b0};
    ar = {sensor_pkg::addr_fixed, strap, 1'b1};
    repeat (12) @(posedge clk);
    @(negedge clk) reset <= 1'b0;
    repeat (300) @(negedge clk);
    rw(w);
    `CHK("temp", exp_t(sensor_pkg::res_mask_9), w)
    for (int i = 1; i < 4; i++) begin
      wr('{aw, 8'(i)}, ak);
      `CHK("ptr ack", 5'h03, ak)
      rw(w);
      `CHK("reg", rv[i], w)
      rw(w);
      `CHK("reread", rv[i], w)
    end
    wr('{aw, 8'h05, 8'h12, 8'h34}, ak);
    `CHK("bad ptr ack", 5'h03, ak)
    rw(w);
    `CHK("ptr kept", sensor_pkg::high_reset, w)
    wr('{aw, 8'h00, 8'h12, 8'h34}, ak);
    `CHK("temp wr ack", 5'h03, ak)
    rw(w);
    `CHK("temp kept", exp_t(sensor_pkg::res_mask_9), w)
    wr('{aw ^ 8'h02, 8'h01}, ak);
    `CHK("other addr", 5'h00, ak)
    wr('{aw, 8'h02, 8'h10, 8'h00}, ak);
    wr('{aw, 8'h02, 8'h0F, 8'h80}, ak);
    `CHK("lim ack", 5'h0F, ak)
    rw(w);
    `CHK("low", 16'h0F80, w)
    wr('{aw, 8'h01, 8'h60}, ak);
    rd(1, b);
    `CHK("cfg msb", 8'h60, b[0])
    wr('{aw, 8'h00}, ak);
    repeat (300) @(negedge clk);
    rw(w);
    `CHK("temp 12b", exp_t(sensor_pkg::res_mask_12), w)
    cval = 12'hF5E;
    repeat (300) @(negedge clk);
    rd(3, b);
    `CHK("neg", exp_t(sensor_pkg::res_mask_12), {b[0], b[1]})
    `CHK("again", exp_t(sensor_pkg::res_mask_12) >> 8, b[2])
    wr('{aw, 8'h01, 8'h01}, ak);
    repeat (20) @(negedge clk);
    `CHK("sd", 1'b1, shutdown_active)
    nc = n_conv;
    repeat (400) @(negedge clk);
    `CHK("no conv", nc, n_conv)
    cval = 12'h194;
    wr('{aw, 8'h01, 8'h81}, ak);
    repeat (300) @(negedge clk);
    `CHK("one shot", nc + 1, n_conv)
    rd(1, b);
    `CHK("os clear", 8'h01, b[0])
    wr('{aw, 8'h03, 8'h10, 8'h00}, ak);
    wr('{aw, 8'h02, 8'h08, 8'h00}, ak);
    wr('{aw, 8'h01, 8'h00}, ak);
    repeat (300) @(negedge clk);
    `CHK("alert on", 1'b0, alert_pin)
    wr('{aw, 8'h01, 8'h01}, ak);
    repeat (300) @(negedge clk);
    `CHK("alert kept", 1'b0, alert_pin)
    wr('{aw, 8'h01, 8'h02}, ak);
    wr('{aw, 8'h01, 8'h03}, ak);
    repeat (50) @(negedge clk);
    `CHK("alert off", 1'b1, alert_pin)
    wr('{aw, 8'h01, 8'h81}, ak);
    repeat (300) @(negedge clk);
    `CHK("os alert", 1'b0, alert_pin)
    finish_test();
  end
endmodule
`default_nettype wire

// ---- temp_sensor_register_access.sv ----
// Operation
// - in shutdown only the serial side stays alive; no conversions start except one run by the single measure bit
// - the configuration shutdown control bit enters and leaves shutdown
// - interrupt mode: entering shutdown drives the alarm inactive
// - comparator mode: entering shutdown leaves the alarm unchanged
// - fault counter survives shutdown; only reset or an in-limit result clears it
// - interrupt mode: leaving shutdown alarms on valid alternating fault
// - single measure bit in shutdown runs exactly one conversion
// - single measurement updates the fault counter like a normal one
// - comparator mode: one-shot fault sets alarm high event, clears on low
// - interrupt mode: one-shot fault pulses alarm briefly, then clears
// - pointer codes 0 to 3 select temperature, config, low, high
// - reads keep returning the selected register until pointer rewritten
// - first data byte of every write transfer is the pointer
// - invalid pointer byte is acknowledged but changes nothing
// - address byte is 1001 plus three strap bits, then acknowledged
// - pointer is zero after reset
// - temperature is 16 bit two's complement, left aligned, low bits zero
// - bit 15 of the temperature is the sign
// - reading temperature never disturbs conversions
// - configuration upper byte alone is a complete access
// - new result waits while the temperature is being read
// - read: upper byte, ack for lower, nack ends, ack restarts fresh
// - writes to the temperature register are refused with a nack
// - comparator mode after reset
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_register_access #(
  parameter int unsigned conv_gap_cycles = sensor_pkg::conv_gap_cycles
) (
  // core clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial link
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] address_strap_pins,
  // converter
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_value,
  // alarm and status
  output logic alert_pin,
  output logic shutdown_active
);

  typedef enum logic [6:0] {
    st_idle = 7'b0000001,
    st_addr = 7'b0000010,
    st_addr_ack = 7'b0000100,
    st_wr = 7'b0001000,
    st_wr_ack = 7'b0010000,
    st_rd = 7'b0100000,
    st_rd_ack = 7'b1000000
  } link_state_e;

  // link domain
  logic [1:0] lrst_s;
  logic lrst;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic [2:0] strap_a;
  logic [2:0] strap_b;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  link_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] out_sr;
  logic is_read;
  logic rd_lsb;
  logic [1:0] byte_idx;
  logic [7:0] msb_hold;
  logic [1:0] ptr;
  logic ptr_ok;
  sensor_pkg::wr_req_s wr_req;
  logic wr_tg;
  logic rd_tg;
  logic end_tg;

  // core domain
  logic [1:0] wr_s;
  logic [1:0] rd_s;
  logic [1:0] end_s;
  logic wr_q;
  logic rd_q;
  logic end_q;
  logic wr_ev;
  logic rd_ev;
  logic end_ev;
  sensor_pkg::cfg_s cfg;
  logic [15:0] low_lim;
  logic [15:0] high_lim;
  logic [15:0] temp;
  logic [15:0] temp_pend;
  logic pend;
  logic read_busy;
  logic [15:0] rd_hold;
  logic [31:0] gap_cnt;
  logic conv_busy;
  logic os_run;
  logic os_done;
  logic res_done;
  logic [15:0] new_temp;

  // result mask for the selected resolution
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    unique case (res)
      2'h0: res_mask = sensor_pkg::res_mask_9;
      2'h1: res_mask = sensor_pkg::res_mask_10;
      2'h2: res_mask = sensor_pkg::res_mask_11;
      2'h3: res_mask = sensor_pkg::res_mask_12;
    endcase
  endfunction

  // acknowledge decision for a received write byte
  function automatic logic accept(input logic [1:0] idx,
                                  input logic [1:0] sel,
                                  input logic ok);
    if (idx == 2'h0) begin
      accept = 1'b1;
    end else if (!ok || sel == sensor_pkg::sel_temp) begin
      accept = 1'b0;
    end else begin
      accept = idx != 2'h3;
    end
  endfunction

  // link reset and pin synchronisers
  always_ff @(posedge link_clk) begin
    lrst_s <= {lrst_s[0], reset};
    scl_s <= {scl_s[0], scl_in};
    sda_s <= {sda_s[0], sda_in};
    strap_a <= address_strap_pins;
    strap_b <= strap_a;
    scl_q <= scl_s[1];
    sda_q <= sda_s[1];
  end

  // bus conditions seen on the synchronised pins
  assign lrst = lrst_s[1];
  assign scl_rise = scl_s[1] && !scl_q;
  assign scl_fall = !scl_s[1] && scl_q;
  assign start_c = scl_s[1] && scl_q && sda_q && !sda_s[1];
  assign stop_c = scl_s[1] && scl_q && !sda_q && sda_s[1];

  // data line is only ever pulled low
  always_ff @(posedge link_clk) begin
    sda_out <= 1'b0;
  end

  // serial slave state machine
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      out_sr <= 8'h00;
      sda_oe <= 1'b0;
      is_read <= 1'b0;
      rd_lsb <= 1'b0;
      byte_idx <= 2'h0;
      msb_hold <= 8'h00;
      ptr <= sensor_pkg::select_reset;
      ptr_ok <= 1'b0;
      wr_req <= '0;
      wr_tg <= 1'b0;
      rd_tg <= 1'b0;
      end_tg <= 1'b0;
    end else if (start_c || stop_c) begin
      if (state == st_rd || state == st_rd_ack) begin
        end_tg <= ~end_tg;
      end
      sda_oe <= 1'b0;
      bit_cnt <= 4'h0;
      state <= start_c ? st_addr : st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          sda_oe <= 1'b0;
        end
        st_addr: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (shift[7:1] == {sensor_pkg::addr_fixed, strap_b}) begin
              state <= st_addr_ack;
              sda_oe <= 1'b1;
              is_read <= shift[0];
              rd_lsb <= 1'b0;
              if (shift[0]) begin
                rd_tg <= ~rd_tg;
              end
            end else begin
              state <= st_idle;
            end
          end
        end
        st_addr_ack: begin
          if (scl_fall) begin
            byte_idx <= 2'h0;
            if (is_read) begin
              state <= st_rd;
              out_sr <= rd_hold[15:8];
              sda_oe <= ~rd_hold[15];
              bit_cnt <= 4'h1;
            end else begin
              state <= st_wr;
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
            end
          end
        end
        st_wr: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            state <= st_wr_ack;
            sda_oe <= accept(byte_idx, ptr, ptr_ok);
            if (byte_idx != 2'h3) begin
              byte_idx <= byte_idx + 2'h1;
            end
            if (byte_idx == 2'h0) begin
              ptr_ok <= shift[7:2] == 6'h00;
              if (shift[7:2] == 6'h00) begin
                ptr <= shift[1:0];
              end
            end else if (byte_idx == 2'h1 && ptr_ok) begin
              msb_hold <= shift;
              if (ptr == sensor_pkg::sel_cfg) begin
                wr_req <= '{sel: ptr, data: {shift, 8'h00}};
                wr_tg <= ~wr_tg;
              end
            end else if (byte_idx == 2'h2 && ptr_ok
                         && ptr[1]) begin
              wr_req <= '{sel: ptr, data: {msb_hold, shift}};
              wr_tg <= ~wr_tg;
            end
          end
        end
        st_wr_ack: begin
          if (scl_fall) begin
            state <= st_wr;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
          end
        end
        st_rd: begin
          if (scl_fall && bit_cnt == 4'h8) begin
            state <= st_rd_ack;
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            sda_oe <= ~out_sr[6];
            out_sr <= {out_sr[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        st_rd_ack: begin
          if (scl_rise && sda_s[1]) begin
            state <= st_idle;
            end_tg <= ~end_tg;
          end else if (scl_rise && rd_lsb) begin
            rd_tg <= ~rd_tg;
          end else if (scl_fall) begin
            state <= st_rd;
            bit_cnt <= 4'h1;
            rd_lsb <= ~rd_lsb;
            out_sr <= rd_lsb ? rd_hold[15:8] : rd_hold[7:0];
            sda_oe <= rd_lsb ? ~rd_hold[15] : ~rd_hold[7];
          end
        end
      endcase
    end
  end

  // event toggles from the link brought into the core clock
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_s <= 2'h0;
      rd_s <= 2'h0;
      end_s <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      wr_s <= {wr_s[0], wr_tg};
      rd_s <= {rd_s[0], rd_tg};
      end_s <= {end_s[0], end_tg};
      wr_q <= wr_s[1];
      rd_q <= rd_s[1];
      end_q <= end_s[1];
    end
  end

  assign wr_ev = wr_s[1] ^ wr_q;
  assign rd_ev = rd_s[1] ^ rd_q;
  assign end_ev = end_s[1] ^ end_q;

  // configuration register
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= sensor_pkg::cfg_s'(sensor_pkg::cfg_reset[15:8]);
    end else if (wr_ev && wr_req.sel == sensor_pkg::sel_cfg) begin
      cfg <= sensor_pkg::cfg_s'(wr_req.data[15:8]);
    end else if (os_done) begin
      cfg.single_measure_bit <= 1'b0;
    end
  end

  // limit registers
  always_ff @(posedge clk) begin
    if (reset) begin
      low_lim <= sensor_pkg::low_reset;
      high_lim <= sensor_pkg::high_reset;
    end else if (wr_ev && wr_req.sel == sensor_pkg::sel_low) begin
      low_lim <= wr_req.data;
    end else if (wr_ev && wr_req.sel == sensor_pkg::sel_high) begin
      high_lim <= wr_req.data;
    end
  end

  // conversion scheduler: periodic when awake, one-shot in shutdown
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_cnt <= 32'h0;
      conv_busy <= 1'b0;
      conv_start <= 1'b0;
      os_run <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (conv_busy) begin
        if (conv_done) begin
          conv_busy <= 1'b0;
          os_run <= 1'b0;
        end
      end else if (!cfg.shutdown_control_bit) begin
        if (gap_cnt == 32'h0) begin
          conv_start <= 1'b1;
          conv_busy <= 1'b1;
          gap_cnt <= 32'(conv_gap_cycles) - 32'h1;
        end else begin
          gap_cnt <= gap_cnt - 32'h1;
        end
      end else if (cfg.single_measure_bit) begin
        conv_start <= 1'b1;
        conv_busy <= 1'b1;
        os_run <= 1'b1;
      end
    end
  end

  assign res_done = conv_busy && conv_done;
  assign os_done = res_done && os_run;
  assign new_temp = {conv_value, 4'h0} & res_mask(cfg.res);

  // temperature register, held back while a read is in progress
  always_ff @(posedge clk) begin
    if (reset) begin
      temp <= sensor_pkg::temp_reset;
      temp_pend <= sensor_pkg::temp_reset;
      pend <= 1'b0;
    end else if (res_done && read_busy) begin
      temp_pend <= new_temp;
      pend <= 1'b1;
    end else if (res_done) begin
      temp <= new_temp;
      pend <= 1'b0;
    end else if (pend && (!read_busy || rd_ev)) begin
      temp <= temp_pend;
      pend <= 1'b0;
    end
  end

  // read tracking; reading only snapshots, never stalls conversions
  always_ff @(posedge clk) begin
    if (reset) begin
      read_busy <= 1'b0;
    end else if (rd_ev) begin
      read_busy <= 1'b1;
    end else if (end_ev) begin
      read_busy <= 1'b0;
    end
  end

  // read word selected by the pointer, held for the link
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_hold <= sensor_pkg::temp_reset;
    end else if (rd_ev) begin
      unique case (ptr)
        sensor_pkg::sel_temp: rd_hold <= pend ? temp_pend : temp;
        sensor_pkg::sel_cfg: rd_hold <= {cfg, 8'h00};
        sensor_pkg::sel_low: rd_hold <= low_lim;
        sensor_pkg::sel_high: rd_hold <= high_lim;
      endcase
    end
  end

  // status output
  always_ff @(posedge clk) begin
    if (reset) begin
      shutdown_active <= 1'b0;
    end else begin
      shutdown_active <= cfg.shutdown_control_bit;
    end
  end

  // fault queue and alarm pin
  alert_qualifier u_alert (
    .clk(clk),
    .reset(reset),
    .result_valid(res_done),
    .result(new_temp),
    .one_shot(os_run),
    .low_lim(low_lim),
    .high_lim(high_lim),
    .cfg(cfg),
    .reg_read(rd_ev),
    .alert_pin(alert_pin)
  );

endmodule
`default_nettype wire

// ---- tsra_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module tsra_checker #(
  parameter int unsigned conv_gap_cycles = sensor_pkg::conv_gap_cycles
) (
  // clocks and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // converter and status
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic alert_pin,
  input wire logic shutdown_active
);
  logic busy;
  logic [15:0] since_ack;
  logic [15:0] idle;
  // conversion outstanding between start and done
  always_ff @(posedge clk) begin
    if (reset) busy <= 1'b0;
    else if (conv_start) busy <= 1'b1;
    else if (conv_done) busy <= 1'b0;
  end
  // cycles since the device last pulled sda
  always_ff @(posedge clk) begin
    if (reset || sda_oe) since_ack <= 16'h0000;
    else if (since_ack != 16'hFFFF) since_ack <= since_ack + 16'h0001;
  end
  // awake cycles with no conversion running
  always_ff @(posedge clk) begin
    if (reset || conv_start || busy || shutdown_active) idle <= 16'h0000;
    else if (idle != 16'hFFFF) idle <= idle + 16'h0001;
  end
  property p_rst_state;
    @(posedge clk) reset |=> alert_pin && !conv_start && !shutdown_active;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state");
  property p_conv_pulse;
    @(posedge clk) disable iff (reset) conv_start |=> !conv_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("long start");
  property p_one_conv;
    @(posedge clk) disable iff (reset) conv_start |-> !busy;
  endproperty
  a_one_conv: assert property (p_one_conv) else $error("start busy");
  property p_conv_gap;
    @(posedge clk) disable iff (reset) 32'(idle) <= conv_gap_cycles + 8;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("no conversion");
  property p_sd_quiet;
    @(posedge clk) disable iff (reset)
      conv_start && shutdown_active && $past(shutdown_active)
      |-> 32'(since_ack) <= conv_gap_cycles + 40;
  endproperty
  a_sd_quiet: assert property (p_sd_quiet) else $error("shutdown conv");
  property p_sd_cause;
    @(posedge clk) disable iff (reset)
      $changed(shutdown_active) |-> since_ack < 16'h0028;
  endproperty
  a_sd_cause: assert property (p_sd_cause) else $error("shutdown moved");
  property p_sda_edge;
    @(posedge link_clk) disable iff (reset) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("sda moved");
  property p_sda_low;
    @(posedge link_clk) disable iff (reset) !sda_out;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda driven high");
  // main scenarios
  c_sd_conv: cover property (@(posedge clk) conv_start && shutdown_active);
  c_alert: cover property (@(posedge clk) $fell(alert_pin));
  c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule
bind temp_sensor_register_access tsra_checker #(
  .conv_gap_cycles(conv_gap_cycles)
) chk (
  .clk(clk), .reset(reset), .link_clk(link_clk), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start),
  .conv_done(conv_done), .alert_pin(alert_pin),
  .shutdown_active(shutdown_active)
);
`default_nettype wire
